/* design/tvr_readout.sv */
// Digital readout of the temperature and voltage measurement path
// What this block does
// RULE1 - Single-channel mode converts only the selected input
// RULE2 - Select codes: 001,010,101,110,111 map channels
// RULE3 - Voltage codes are unsigned 10-bit, saturating
// RULE4 - Temperature MSBs go to three value registers
// RULE5 - Temperatures use offset-64 or twos complement
// RULE6 - Config5 bit0 selects twos complement storage
// RULE7 - Range -128..127 or -64..191, quarter degree
// RULE8 - Sixteen raw samples average into each value
// RULE9 - Remote measurement nominally takes 38 ms
// RULE10 - Two low bits kept in extended register
// RULE11 - Ext bits: remote2 7:6, local 5:4, remote1 3:2
// RULE12 - Channel offset added before storing temperature
// RULE13 - Remote offsets are signed 8-bit, always added
// RULE14 - Software programs summed offsets per channel
// RULE15 - Value updates only after full averaging
module tvr_readout
    import tvr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire tvr_pkg::tvr_reg_req_t regReq,
    output logic [7:0] regRdata,
    // Front end conversion stream and channel request
    input wire tvr_pkg::tvr_sample_t sample,
    output logic [2:0] convChan,
    output logic convStart
);
    import tvr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Software registers
    logic [7:0] fan1MinCountHigh_reg; // Upper bits hold channel select
    logic [7:0] config2_reg; // Averaging and single-channel controls
    logic [7:0] config5_reg; // Temperature format control
    logic [7:0] offsets_reg [3]; // Remote1, local, remote2 offsets
    logic [7:0] tempValue_reg [3]; // Stored temperature MSBs
    logic [1:0] tempLow_reg [3]; // Stored quarter-degree bits
    logic [9:0] chipsetCode_reg; // Chipset supply code
    logic [9:0] vccCode_reg; // Own supply code
    logic [2:0] chanSel;
    logic singleMode;
    logic avgOff;
    logic twosMode;

    assign chanSel = fan1MinCountHigh_reg[ChanSelLsb +: 3];
    assign singleMode = config2_reg[Cfg2SingleBit];
    assign avgOff = config2_reg[Cfg2AvgOffBit];
    assign twosMode = config5_reg[Cfg5TwosBit]; // RULE6

    // Register writes; offsets carry the summed correction software chose
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fan1MinCountHigh_reg <= ResetZero;
            config2_reg <= ResetZero;
            config5_reg <= ResetConfig5;
            offsets_reg[0] <= ResetZero;
            offsets_reg[1] <= ResetZero;
            offsets_reg[2] <= ResetZero;
        end else if (regReq.write) begin
            unique case (regReq.addr)
                OffFan1MinCountHigh: fan1MinCountHigh_reg <= regReq.wdata; // RULE1
                OffConfig2: config2_reg <= regReq.wdata;
                OffConfig5: config5_reg <= regReq.wdata;
                OffRemote1Offset: offsets_reg[0] <= regReq.wdata; // RULE13 RULE14
                OffLocalOffset: offsets_reg[1] <= regReq.wdata;
                OffRemote2Offset: offsets_reg[2] <= regReq.wdata; // RULE13 RULE14
                default: ; // Other addresses are read-only or unmapped
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion scheduler: round robin, or one channel in single mode
    logic [2:0] rrIdx_reg;
    logic [2:0] rrChan;
    logic [31:0] waitCnt_reg; // Gap between conversion requests
    logic samplesDone; // This sample closes an average
    logic isTemp; // Sample belongs to a temperature channel

    // Round-robin order over the five channels
    always_comb begin
        unique case (rrIdx_reg)
            3'h0: rrChan = TVR_CH_CHIPSET;
            3'h1: rrChan = TVR_CH_VCC;
            3'h2: rrChan = TVR_CH_REMOTE1;
            3'h3: rrChan = TVR_CH_LOCAL;
            default: rrChan = TVR_CH_REMOTE2;
        endcase
    end

    // Issue a start each time the previous sample returns
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            rrIdx_reg <= 3'h0;
            convChan <= TVR_CH_NONE;
            convStart <= 1'b0;
            waitCnt_reg <= 32'h0;
        end else begin
            convStart <= 1'b0;
            if (waitCnt_reg == 32'h0) begin
                convStart <= 1'b1;
                convChan <= singleMode ? chanSel : rrChan; // RULE1 RULE2
                // Remote 38 ms budget spread over sixteen raw samples
                waitCnt_reg <= 32'(RemoteCycles / AvgCount); // RULE9
            end else if (sample.valid) begin
                waitCnt_reg <= 32'h0;
                if (samplesDone)
                    rrIdx_reg <= (rrIdx_reg == 3'h4) ? 3'h0 : rrIdx_reg + 3'h1;
            end else begin
                waitCnt_reg <= waitCnt_reg - 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Averaging accumulator
    logic [13:0] accum_reg;
    logic [3:0] avgCnt_reg;
    logic [13:0] accumNext;
    logic [9:0] avgCode;

    // Temperature codes are signed, so they are sign-extended; readings of both signs then average correctly
    assign accumNext = accum_reg + {{4{isTemp & sample.code[9]}}, sample.code};
    assign samplesDone = avgOff || (avgCnt_reg == 4'(AvgCount - 1)); // RULE8 RULE15
    assign avgCode = avgOff ? sample.code : accumNext[AvgShift +: 10]; // RULE8

    // Sum sixteen raw codes, restart after each result
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            accum_reg <= 14'h0;
            avgCnt_reg <= 4'h0;
        end else if (sample.valid) begin
            if (samplesDone) begin
                accum_reg <= 14'h0;
                avgCnt_reg <= 4'h0;
            end else begin
                accum_reg <= accumNext;
                avgCnt_reg <= avgCnt_reg + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Temperature format: signed quarter-degree plus offset, then clamp
    logic [1:0] tIdx;
    logic [11:0] tempSum;
    logic [11:0] tempClamped;
    logic [9:0] tempCode;

    always_comb begin
        isTemp = 1'b1;
        unique case (sample.chan)
            TVR_CH_REMOTE1: tIdx = 2'h0;
            TVR_CH_LOCAL: tIdx = 2'h1;
            TVR_CH_REMOTE2: tIdx = 2'h2;
            default: begin
                tIdx = 2'h0;
                isTemp = 1'b0;
            end
        endcase
    end

    // Offset is whole degrees, so it lands above the two fraction bits
    assign tempSum = {{2{avgCode[9]}}, avgCode} + {{2{offsets_reg[tIdx][7]}}, offsets_reg[tIdx], 2'h0}; // RULE12

    // Clamp to the range of the active format and re-bias for offset-64
    always_comb begin
        if (twosMode) begin
            if ($signed(tempSum) < $signed(TempMinTwos)) tempClamped = TempMinTwos; // RULE7
            else if ($signed(tempSum) > $signed(TempMaxTwos)) tempClamped = TempMaxTwos;
            else tempClamped = tempSum;
            tempCode = tempClamped[9:0]; // RULE5
        end else begin
            if ($signed(tempSum) < $signed(TempMinExt)) tempClamped = TempMinExt; // RULE7
            else if ($signed(tempSum) > $signed(TempMaxExt)) tempClamped = TempMaxExt;
            else tempClamped = tempSum;
            tempCode = 10'(tempClamped + ExtOffset64); // RULE5
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result registers, written only when an average completes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            for (int i = 0; i < 3; i++) begin
                tempValue_reg[i] <= ResetZero;
                tempLow_reg[i] <= 2'h0;
            end
            chipsetCode_reg <= 10'h0;
            vccCode_reg <= 10'h0;
        end else if (sample.valid && samplesDone) begin // RULE15
            if (isTemp) begin
                tempValue_reg[tIdx] <= tempCode[9:2]; // RULE4
                tempLow_reg[tIdx] <= tempCode[1:0]; // RULE10
            end else if (sample.chan == TVR_CH_CHIPSET) begin
                chipsetCode_reg <= (avgCode > CodeMax) ? CodeMax : avgCode; // RULE3
            end else if (sample.chan == TVR_CH_VCC) begin
                vccCode_reg <= (avgCode > CodeMax) ? CodeMax : avgCode; // RULE3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux, registered
    logic [7:0] extRes2;
    logic [7:0] extRes1;

    always_comb begin
        extRes2 = 8'h0;
        extRes2[ExtRemote2Lsb +: 2] = tempLow_reg[2]; // RULE11
        extRes2[ExtLocalLsb +: 2] = tempLow_reg[1]; // RULE11
        extRes2[ExtRemote1Lsb +: 2] = tempLow_reg[0]; // RULE11
        extRes1 = 8'h0;
        extRes1[ExtChipsetLsb +: 2] = chipsetCode_reg[1:0];
        extRes1[ExtVccLsb +: 2] = vccCode_reg[1:0];
    end

    // Unmapped addresses read as zero
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            regRdata <= 8'h0;
        end else if (regReq.read) begin
            unique case (regReq.addr)
                OffChipsetValue: regRdata <= chipsetCode_reg[9:2];
                OffVccValue: regRdata <= vccCode_reg[9:2];
                OffRemote1Value: regRdata <= tempValue_reg[0]; // RULE4
                OffLocalValue: regRdata <= tempValue_reg[1]; // RULE4
                OffRemote2Value: regRdata <= tempValue_reg[2]; // RULE4
                OffFan1MinCountHigh: regRdata <= fan1MinCountHigh_reg;
                OffRemote1Offset: regRdata <= offsets_reg[0];
                OffLocalOffset: regRdata <= offsets_reg[1];
                OffRemote2Offset: regRdata <= offsets_reg[2];
                OffConfig2: regRdata <= config2_reg;
                OffExtRes1: regRdata <= extRes1;
                OffExtRes2: regRdata <= extRes2; // RULE10
                OffConfig5: regRdata <= config5_reg;
                default: regRdata <= 8'h0;
            endcase
        end
    end
endmodule : tvr_readout

/* design/tvr_pkg.sv */
// Package for the temperature and voltage readout block: offsets, fields, timing and carriers
package tvr_pkg;
    // Register offsets within the register port
    localparam logic [7:0] OffChipsetValue = 8'h21;
    localparam logic [7:0] OffVccValue = 8'h22;
    localparam logic [7:0] OffRemote1Value = 8'h25;
    localparam logic [7:0] OffLocalValue = 8'h26;
    localparam logic [7:0] OffRemote2Value = 8'h27;
    localparam logic [7:0] OffFan1MinCountHigh = 8'h55;
    localparam logic [7:0] OffRemote1Offset = 8'h70;
    localparam logic [7:0] OffLocalOffset = 8'h71;
    localparam logic [7:0] OffRemote2Offset = 8'h72;
    localparam logic [7:0] OffConfig2 = 8'h73;
    localparam logic [7:0] OffExtRes1 = 8'h76;
    localparam logic [7:0] OffExtRes2 = 8'h77;
    localparam logic [7:0] OffConfig5 = 8'h7c;
    // Field positions
    localparam int ChanSelLsb = 5;
    localparam int Cfg2AvgOffBit = 4;
    localparam int Cfg2SingleBit = 6;
    localparam int Cfg5TwosBit = 0;
    localparam int ExtRemote2Lsb = 6;
    localparam int ExtLocalLsb = 4;
    localparam int ExtRemote1Lsb = 2;
    localparam int ExtChipsetLsb = 0;
    localparam int ExtVccLsb = 2;
    // Reset values
    localparam logic [7:0] ResetZero = 8'h00;
    localparam logic [7:0] ResetConfig5 = 8'h00;
    // Code limits and format constants
    localparam logic [9:0] CodeMax = 10'h3ff;
    localparam logic [9:0] CodeNominalSupply = 10'h300;
    localparam logic [11:0] ExtOffset64 = 12'h100;
    localparam logic [11:0] TempMinTwos = 12'he00;
    localparam logic [11:0] TempMaxTwos = 12'h1ff;
    localparam logic [11:0] TempMaxExt = 12'h2ff;
    localparam logic [11:0] TempMinExt = 12'hf00;
    // Averaging
    localparam int AvgCount = 16;
    localparam int AvgShift = 4;
    // Measurement timing
    localparam int ClockMhz = 125;
    localparam int RemoteTimeMs = 38;
    localparam int RemoteCycles = RemoteTimeMs * 1000 * ClockMhz;
    // Channel select codes
    typedef enum logic [2:0] {
        TVR_CH_NONE = 3'b000,
        TVR_CH_CHIPSET = 3'b001,
        TVR_CH_VCC = 3'b010,
        TVR_CH_REMOTE1 = 3'b101,
        TVR_CH_LOCAL = 3'b110,
        TVR_CH_REMOTE2 = 3'b111
    } tvr_chan_t;
    // Register port request
    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tvr_reg_req_t;
    // Raw conversion from the analog front end
    typedef struct packed {
        logic valid;
        logic [2:0] chan;
        logic [9:0] code;
    } tvr_sample_t;
endpackage : tvr_pkg

/* dv/tvr_readout_sva.sv */
// Port checker for the readout block
module tvr_readout_sva
    import tvr_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire tvr_pkg::tvr_reg_req_t regReq,
    input wire logic [7:0] regRdata,
    // Front end side
    input wire tvr_pkg::tvr_sample_t sample,
    input wire logic [2:0] convChan,
    input wire logic convStart
);
    logic [7:0] fanReg; // Shadow of the select register
    logic singleReg; // Shadow of single-channel mode
    logic [1:0] quietReg; // Cycles since a mode write, saturating
    wire wrFan = regReq.write && regReq.addr == OffFan1MinCountHigh;
    wire wrCfg = regReq.write && regReq.addr == OffConfig2;
    //////////////////////////////////////////////////
    // Shadows follow host writes
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            fanReg <= 8'h00;
            singleReg <= 1'b0;
        end else if (wrFan) begin
            fanReg <= regReq.wdata;
        end else if (wrCfg) begin
            singleReg <= regReq.wdata[Cfg2SingleBit];
        end
    end
    // A request may already be queued when the mode changes, so wait a little
    always_ff @(posedge mclk) begin
        if (!resetn || wrFan || wrCfg) begin
            quietReg <= 2'h0;
        end else if (quietReg != 2'h3) begin
            quietReg <= quietReg + 2'h1;
        end
    end
    //////////////////////////////////////////////////
    sequence s_read_fan;
        regReq.read && regReq.addr == OffFan1MinCountHigh;
    endsequence
    sequence s_read_hole;
        regReq.read && regReq.addr == 8'h01;
    endsequence
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    a_start_once: assert property (convStart |=> !convStart) else $error("start longer than one cycle");
    a_single_chan: assert property (
        convStart && singleReg && quietReg == 2'h3 |-> convChan == fanReg[7:5]) else $error("wrong single channel");
    a_chan_legal: assert property (
        convStart |-> convChan inside {3'b001, 3'b010, 3'b101, 3'b110, 3'b111}) else $error("bad channel code");
    a_fan_readback: assert property (
        s_read_fan |=> regRdata == $past(fanReg)) else $error("select register readback wrong");
    a_hole_zero: assert property (s_read_hole |=> regRdata == 8'h00) else $error("unmapped read not zero");
    a_read_hold: assert property (!regReq.read |=> $stable(regRdata)) else $error("read data moved");
    a_rose_clear: assert property ($rose(resetn) |-> regRdata == 8'h00 && !convStart) else $error("not clear");
    a_reset_quiet: assert property (disable iff (1'b0)
        !resetn |=> !convStart && regRdata == 8'h00) else $error("outputs active in reset");
endmodule : tvr_readout_sva
bind tvr_readout tvr_readout_sva tvr_readout_sva_i (.mclk(mclk), .resetn(resetn), .regReq(regReq),
    .regRdata(regRdata), .sample(sample), .convChan(convChan), .convStart(convStart));

/* dv/tvr_front_end_model.sv */
// Front end model: answers each conversion request with one raw sample
module tvr_front_end_model
    import tvr_pkg::*;
#(
    parameter int Delay = 4
)(
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Requests from the readout block
    input wire logic convStart,
    input wire logic [2:0] convChan,
    // Level from the bench, optional alternating noise
    input wire logic [9:0] level,
    input wire logic noiseEn,
    // Conversion result
    output tvr_pkg::tvr_sample_t sample
);
    int waitReg; // Cycles to the answer, 0 when idle
    logic [2:0] chanReg; // Channel captured at the request
    logic flipReg; // Alternates the noise step
    // Outside the answer cycle the fields keep changing, so stale data is never mistaken for a result
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            sample <= 14'h0000;
            waitReg <= 0;
            flipReg <= 1'b0;
        end else begin
            sample <= {1'b0, ~sample.chan, ~sample.code};
            if (convStart) begin
                waitReg <= Delay;
                chanReg <= convChan;
            end else if (waitReg == 1) begin
                sample <= {1'b1, chanReg, level + ((noiseEn && flipReg) ? 10'h004 : 10'h000)};
                flipReg <= ~flipReg;
                waitReg <= 0;
            end else if (waitReg != 0) begin
                waitReg <= waitReg - 1;
            end
        end
    end
endmodule : tvr_front_end_model

/* dv/testbench.sv */
// Self-checking bench for the readout block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import tvr_pkg::*;
    typedef struct packed {
        logic [2:0] sel;
        logic [9:0] code;
        logic twos;
        logic [7:0] offA, offV, valA, valE, extA, extM, extE;
    } tvr_row_t;
    logic mclk = 1'b0, resetn = 1'b0, noiseEn = 1'b0, convStart;
    logic [2:0] convChan;
    logic [9:0] level = 10'h000;
    logic [7:0] regRdata, d;
    tvr_reg_req_t req = 18'h00000;
    tvr_sample_t smp;
    int failCount = 0, checksDone = 0;
    // Rows: channel, raw code, format, offset, then expected value and low bits
    tvr_row_t rows [9] = '{
        '{3'b110, 10'h029, 1'b1, 8'h71, 8'h00, 8'h26, 8'h0a, 8'h77, 8'h30, 8'h10},
        '{3'b101, 10'h066, 1'b1, 8'h70, 8'h00, 8'h25, 8'h19, 8'h77, 8'h0c, 8'h08},
        '{3'b111, 10'h064, 1'b0, 8'h72, 8'h00, 8'h27, 8'h59, 8'h77, 8'hc0, 8'h00},
        '{3'b101, 10'h064, 1'b1, 8'h70, 8'h02, 8'h25, 8'h1b, 8'h77, 8'h0c, 8'h00},
        '{3'b111, 10'h000, 1'b1, 8'h72, 8'hff, 8'h27, 8'hff, 8'h77, 8'hc0, 8'h00},
        '{3'b110, 10'h200, 1'b0, 8'h71, 8'h00, 8'h26, 8'h00, 8'h77, 8'h30, 8'h00},
        '{3'b111, 10'h1fc, 1'b0, 8'h72, 8'h40, 8'h27, 8'hff, 8'h77, 8'hc0, 8'h00},
        '{3'b001, 10'h300, 1'b0, 8'h71, 8'h00, 8'h21, 8'hc0, 8'h76, 8'h03, 8'h00},
        '{3'b010, 10'h3ff, 1'b0, 8'h71, 8'h00, 8'h22, 8'hff, 8'h76, 8'h0c, 8'h0c}};
    logic [2:0] rrExp [5] = '{3'b001, 3'b010, 3'b101, 3'b110, 3'b111};
    logic [7:0] rstA [6] = '{8'h55, 8'h70, 8'h71, 8'h72, 8'h73, 8'h7c};
    tvr_readout tvr_readout_i (.mclk(mclk), .resetn(resetn), .regReq(req), .regRdata(regRdata),
        .sample(smp), .convChan(convChan), .convStart(convStart));
    tvr_front_end_model tvr_front_end_model_i (.mclk(mclk), .resetn(resetn), .convStart(convStart),
        .convChan(convChan), .level(level), .noiseEn(noiseEn), .sample(smp));
    //////////////////////////////////////////////////
    initial begin
        forever #4 mclk = ~mclk;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, a, v};
        @(posedge mclk);
        req.write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge mclk);
        req.read <= 1'b0;
        @(posedge mclk);
        #1 v = regRdata;
    endtask : rd
    task automatic cmp8(input string n, input logic [7:0] e, input logic [7:0] s);
        checksDone++;
        if (s !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : cmp8
    task automatic cmpChan(input string n, input logic [2:0] e, input logic [2:0] s);
        checksDone++;
        if (s !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : cmpChan
    // Counts requests for one channel, bounded so a stuck scheduler shows up
    task automatic waitConv(input logic [2:0] c, input int n);
        int seen;
        seen = 0;
        for (int k = 0; k < 5000 && seen < n; k++) begin
            @(posedge mclk);
            if (convStart === 1'b1 && convChan === c) seen++;
        end
        cmp8("conversion count", 8'h01, {7'h00, seen >= n});
        repeat (8) @(posedge mclk);
    endtask : waitConv
    task automatic giveVerdict();
        $display("checks %0d errors %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : giveVerdict
    //////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge mclk);
        failCount++;
        giveVerdict();
    end
    initial begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        // Free-running order after reset: each channel holds for a full average before moving on
        for (int i = 0; i < 5 * AvgCount; i++) begin
            do @(posedge mclk); while (convStart !== 1'b1);
            cmpChan("round robin", rrExp[i / AvgCount], convChan);
        end
        foreach (rstA[i]) begin
            rd(rstA[i], d);
            cmp8("reset value", 8'h00, d);
        end
        wr(8'h01, 8'h5a);
        rd(8'h01, d);
        cmp8("unmapped", 8'h00, d);
        // Pick a legal channel before single mode takes effect, so no start carries an unlisted code
        wr(OffFan1MinCountHigh, 8'hc0);
        wr(OffConfig2, 8'h50);
        foreach (rows[i]) begin
            wr(OffConfig5, {7'h00, rows[i].twos});
            wr(rows[i].offA, rows[i].offV);
            level <= rows[i].code;
            wr(OffFan1MinCountHigh, {rows[i].sel, 5'h00});
            rd(OffFan1MinCountHigh, d);
            cmp8("select readback", {rows[i].sel, 5'h00}, d);
            waitConv(rows[i].sel, 2);
            rd(rows[i].valA, d);
            cmp8("value register", rows[i].valE, d);
            rd(rows[i].extA, d);
            cmp8("low bits", rows[i].extE, d & rows[i].extM);
        end
        // Averaging enabled: alternating noise of one degree must average to half a degree
        wr(OffConfig5, 8'h01);
        wr(OffConfig2, 8'h40);
        level <= 10'h028;
        noiseEn <= 1'b1;
        wr(OffFan1MinCountHigh, 8'hc0);
        waitConv(3'b110, 40);
        rd(OffLocalValue, d);
        cmp8("averaged value", 8'h0a, d);
        rd(OffExtRes2, d);
        cmp8("averaged low bits", 8'h20, d & 8'h30);
        // Reset in mid-run clears the registers and restarts the round robin
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        do @(posedge mclk); while (convStart !== 1'b1);
        cmpChan("restart channel", 3'b001, convChan);
        rd(OffFan1MinCountHigh, d);
        cmp8("reset again", 8'h00, d);
        giveVerdict();
    end
endmodule : testbench
